//--- core/sdp_pkg.sv
// shared constants and types for the scan and debug port select block
package sdp_pkg;
    localparam int IR_LEN = 4;
    localparam logic [3:0] INS_EXTEST = 4'h0;
    localparam logic [3:0] INS_SAMPLE = 4'h1;
    localparam logic [3:0] INS_SCAN_N = 4'h2;
    localparam logic [3:0] INS_INTEST = 4'hC;
    localparam logic [3:0] INS_IDCODE = 4'hE;
    localparam logic [3:0] INS_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MAKER_LSB = 1;
    localparam logic ID_FIXED_BIT = 1'b1;
    localparam int ID_LEN = 32;
    localparam int CH1_LEN = 33;
    localparam int CH2_LEN = 38;
    localparam int CHSEL_LEN = 4;
    localparam logic [3:0] CHAIN_DEBUG = 4'h1;
    localparam logic [3:0] CHAIN_EMU = 4'h2;
    localparam logic [3:0] CHSEL_RESET = 4'h0;
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_TIME_NS = 80;
    localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_W = $clog2(POR_CYCLES + 1);
    localparam int TMS_RESET_STEPS = 5;

    typedef enum logic {MODE_EMU, MODE_BSCAN} sdp_mode_t;
    typedef enum logic [2:0] {DR_BYP, DR_ID, DR_BSR, DR_CHSEL, DR_CH1, DR_CH2} sdp_dr_t;
    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SHF_DR, TS_EX1_DR, TS_PAU_DR,
        TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SHF_IR, TS_EX1_IR, TS_PAU_IR,
        TS_EX2_IR, TS_UPD_IR
    } sdp_tap_t;
endpackage : sdp_pkg

//--- core/sdp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sdp_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= '0;
            o_q <= '0;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule : sdp_sync

//--- core/sdp_tap_fsm.sv
// test access port state machine, stepped on each test clock rise
`timescale 1ns/10ps
module sdp_tap_fsm (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_tap_reset,
    input wire logic i_step,
    input wire logic i_tms,
    output sdp_pkg::sdp_tap_t o_state
);
    import sdp_pkg::*;

    sdp_tap_t next_state;

    always_comb begin
        next_state = o_state;
        case (o_state)
            TS_RESET: next_state = i_tms ? TS_RESET : TS_IDLE;
            TS_IDLE: next_state = i_tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: next_state = i_tms ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: next_state = i_tms ? TS_EX1_DR : TS_SHF_DR;
            TS_SHF_DR: next_state = i_tms ? TS_EX1_DR : TS_SHF_DR;
            TS_EX1_DR: next_state = i_tms ? TS_UPD_DR : TS_PAU_DR;
            TS_PAU_DR: next_state = i_tms ? TS_EX2_DR : TS_PAU_DR;
            TS_EX2_DR: next_state = i_tms ? TS_UPD_DR : TS_SHF_DR;
            TS_UPD_DR: next_state = i_tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: next_state = i_tms ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR: next_state = i_tms ? TS_EX1_IR : TS_SHF_IR;
            TS_SHF_IR: next_state = i_tms ? TS_EX1_IR : TS_SHF_IR;
            TS_EX1_IR: next_state = i_tms ? TS_UPD_IR : TS_PAU_IR;
            TS_PAU_IR: next_state = i_tms ? TS_EX2_IR : TS_PAU_IR;
            TS_EX2_IR: next_state = i_tms ? TS_UPD_IR : TS_SHF_IR;
            TS_UPD_IR: next_state = i_tms ? TS_SEL_DR : TS_IDLE;
            default: next_state = TS_RESET;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_state <= TS_RESET;
        end else if (i_tap_reset) begin
            o_state <= TS_RESET;
        end else if (i_step) begin
            o_state <= next_state;
        end
    end

    // helper: count consecutive steps with tms high
    logic [2:0] tms_run;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tms_run <= 3'h0;
        end else if (i_step) begin
            tms_run <= !i_tms ? 3'h0 : (tms_run == 3'h7 ? tms_run : tms_run + 3'h1);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_tms_five;
        tms_run >= 3'(TMS_RESET_STEPS) |-> o_state == TS_RESET;
    endproperty
    a_tms_five: assert property (p_tms_five) else $error("five tms highs not in reset");

    property p_idle_to_select;
        i_step && !i_tap_reset && i_tms && o_state == TS_IDLE |=> o_state == TS_SEL_DR;
    endproperty
    a_idle_to_select: assert property (p_idle_to_select) else $error("tms did not steer");

    property p_hold_no_step;
        !i_step && !i_tap_reset |=> $stable(o_state);
    endproperty
    a_hold_no_step: assert property (p_hold_no_step) else $error("state moved without tck");
endmodule : sdp_tap_fsm

//--- core/sdp_top.sv
// scan and debug port select: emulation chains or boundary scan behind one test port
// Operation
// - Mode select low routes port to emulation.
// - Mode select high routes port to boundary scan.
// - Mode latched at reset; change needs reset.
// - Boundary scan supports SAMPLE, EXTEST, BYPASS.
// - Emulation mode returns core-specific identification value.
// - Device drives test reset at power-up.
// - Returned test clock only in emulation mode.
// - Test mode select steers every state transition except test reset.
// - Test data in feeds the selected register.
// - Test data out shifts selected register out.
// - Debug chain inserts instructions and dumps registers.
// - Two emulation scan chains behind the port.
// - Identification word fields: version, part, maker.
// - Boundary scan identification bit zero reads as one.
// - Debug channel flags become interrupt requests.
// - Software control blocks emulation system access.
// - Read-only chip identification value provided.
`timescale 1ns/10ps
module sdp_top #(
    parameter int BSR_LEN = 16,
    parameter logic [3:0] ID_VERSION = 4'h3,      // arbitrary value
    parameter logic [15:0] ID_PART = 16'hA5C1,    // arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h2B4,    // arbitrary value
    parameter logic [31:0] CORE_ID = 32'h6D1E_42B8, // arbitrary value
    parameter logic [31:0] CHIP_ID = 32'h3C45_9A10  // arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_test_reset_n,
    input wire logic i_scan_mode_select,
    output logic o_tdo,
    output logic o_tdo_en,
    output logic o_returned_test_clock,
    output logic o_test_reset_n,
    output sdp_pkg::sdp_mode_t o_port_mode,
    input wire logic i_core_debug_state,
    input wire logic [31:0] i_core_rdata,
    output logic [31:0] o_core_insn,
    output logic o_core_insn_valid,
    input wire logic [31:0] i_emu_rdata,
    output logic [4:0] o_emu_addr,
    output logic [31:0] o_emu_wdata,
    output logic o_emu_write,
    input wire logic [BSR_LEN-1:0] i_pin_state,
    output logic [BSR_LEN-1:0] o_pin_drive,
    output logic o_pin_extest,
    input wire logic i_debug_channel_send_flag,
    input wire logic i_debug_channel_receive_flag,
    input wire logic i_access_block,
    output logic o_dcc_send_irq,
    output logic o_dcc_receive_irq,
    output logic [31:0] o_chip_id
);
    import sdp_pkg::*;
    localparam int MAXW = BSR_LEN > CH2_LEN ? BSR_LEN : CH2_LEN;
    localparam int LW = $clog2(MAXW + 1);
    logic [1:0] rst_ff;
    logic rst_n;
    logic tck_s, tms_s, tdi_s, trst_s, smsel_s;
    logic tck_d, tck_rise, tck_fall;
    logic [POR_W-1:0] por_cnt;
    logic por_done;
    logic tap_reset;
    sdp_tap_t state;
    logic [IR_LEN-1:0] ir_sr;
    logic [IR_LEN-1:0] ir;
    logic [CHSEL_LEN-1:0] chsel;
    sdp_dr_t dr_sel;
    logic [LW-1:0] dr_len;
    logic [MAXW-1:0] sr;
    logic [MAXW-1:0] sr_shift;
    logic [MAXW-1:0] cap_val;
    logic [31:0] id_word;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_ff <= 2'b00;
        end else begin
            rst_ff <= {rst_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_ff[1];
    sdp_sync #(.W(5)) u_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_d({i_tck, i_tms, i_tdi, i_test_reset_n, i_scan_mode_select}),
        .o_q({tck_s, tms_s, tdi_s, trst_s, smsel_s})
    );
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= tck_s;
        end
    end
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;
    // power-on hold of the test reset; mode sampled once as it ends
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt <= '0;
            por_done <= 1'b0;
            o_port_mode <= MODE_EMU;
        end else if (!por_done) begin
            if (por_cnt == POR_W'(POR_CYCLES)) begin
                por_done <= 1'b1;
                o_port_mode <= smsel_s ? MODE_BSCAN : MODE_EMU;
            end else begin
                por_cnt <= por_cnt + POR_W'(1);
            end
        end
    end
    assign o_test_reset_n = por_done;
    assign tap_reset = !por_done || !trst_s;
    sdp_tap_fsm u_fsm (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_tap_reset(tap_reset),
        .i_step(tck_rise),
        .i_tms(tms_s),
        .o_state(state)
    );
    // instruction register
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_sr <= '0;
            ir <= INS_IDCODE;
        end else if (tap_reset || state == TS_RESET) begin
            ir <= INS_IDCODE;
        end else if (tck_rise) begin
            case (state)
                TS_CAP_IR: ir_sr <= IR_CAPTURE;
                TS_SHF_IR: ir_sr <= {tdi_s, ir_sr[IR_LEN-1:1]};
                TS_UPD_IR: ir <= ir_sr;
                default: ir_sr <= ir_sr;
            endcase
        end
    end
    // data register selection per mode
    always_comb begin
        dr_sel = DR_BYP;
        if (ir == INS_IDCODE) begin
            dr_sel = DR_ID;
        end else if (o_port_mode == MODE_BSCAN) begin
            if (ir == INS_EXTEST || ir == INS_SAMPLE) begin
                dr_sel = DR_BSR;
            end
        end else if (ir == INS_SCAN_N) begin
            dr_sel = DR_CHSEL;
        end else if (ir == INS_INTEST && chsel == CHAIN_DEBUG) begin
            dr_sel = DR_CH1;
        end else if (ir == INS_INTEST && chsel == CHAIN_EMU) begin
            dr_sel = DR_CH2;
        end
    end
    assign id_word = (o_port_mode == MODE_BSCAN) ?
        ((32'(ID_VERSION) << ID_VER_LSB) | (32'(ID_PART) << ID_PART_LSB) |
         (32'(ID_MAKER) << ID_MAKER_LSB) | 32'(ID_FIXED_BIT)) : CORE_ID;
    always_comb begin
        cap_val = '0;
        dr_len = LW'(1);
        case (dr_sel)
            DR_ID: begin
                cap_val[ID_LEN-1:0] = id_word;
                dr_len = LW'(ID_LEN);
            end
            DR_BSR: begin
                cap_val[BSR_LEN-1:0] = i_pin_state;
                dr_len = LW'(BSR_LEN);
            end
            DR_CHSEL: begin
                cap_val[CHSEL_LEN-1:0] = chsel;
                dr_len = LW'(CHSEL_LEN);
            end
            DR_CH1: begin
                cap_val[CH1_LEN-1:0] = {i_core_debug_state, i_core_rdata};
                dr_len = LW'(CH1_LEN);
            end
            DR_CH2: begin
                cap_val[31:0] = i_emu_rdata;
                dr_len = LW'(CH2_LEN);
            end
            default: dr_len = LW'(1);
        endcase
    end
    // tdi enters at the top bit of the selected length
    for (genvar i = 0; i < MAXW; i++) begin : g_shift
        if (i == MAXW - 1) begin : g_top
            assign sr_shift[i] = (dr_len == LW'(i + 1)) ? tdi_s : 1'b0;
        end else begin : g_mid
            assign sr_shift[i] = (dr_len == LW'(i + 1)) ? tdi_s : sr[i+1];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sr <= '0;
        end else if (tck_rise && state == TS_CAP_DR) begin
            sr <= cap_val;
        end else if (tck_rise && state == TS_SHF_DR) begin
            sr <= sr_shift;
        end
    end
    // update of chain select and emulation chains
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            chsel <= CHSEL_RESET;
            o_core_insn <= '0;
            o_core_insn_valid <= 1'b0;
            o_emu_addr <= '0;
            o_emu_wdata <= '0;
            o_emu_write <= 1'b0;
        end else begin
            o_core_insn_valid <= 1'b0;
            o_emu_write <= 1'b0;
            if (tap_reset) begin
                chsel <= CHSEL_RESET;
            end else if (tck_rise && state == TS_UPD_DR) begin
                if (dr_sel == DR_CHSEL) begin
                    chsel <= sr[CHSEL_LEN-1:0];
                end
                if (dr_sel == DR_CH1 && i_core_debug_state && !i_access_block) begin
                    o_core_insn <= sr[31:0];
                    o_core_insn_valid <= 1'b1;
                end
                if (dr_sel == DR_CH2 && sr[CH2_LEN-1] && !i_access_block) begin
                    o_emu_addr <= sr[36:32];
                    o_emu_wdata <= sr[31:0];
                    o_emu_write <= 1'b1;
                end
            end
        end
    end
    // boundary drive values
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pin_drive <= '0;
            o_pin_extest <= 1'b0;
        end else begin
            o_pin_extest <= o_port_mode == MODE_BSCAN && ir == INS_EXTEST && !tap_reset;
            if (tck_rise && state == TS_UPD_DR && dr_sel == DR_BSR && ir == INS_EXTEST) begin
                o_pin_drive <= sr[BSR_LEN-1:0];
            end
        end
    end
    // test data out changes on the falling test clock
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_tdo <= 1'b0;
            o_tdo_en <= 1'b0;
        end else if (tck_fall) begin
            o_tdo_en <= state == TS_SHF_DR || state == TS_SHF_IR;
            o_tdo <= (state == TS_SHF_IR) ? ir_sr[0] : sr[0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_returned_test_clock <= 1'b0;
        end else begin
            o_returned_test_clock <= por_done && o_port_mode == MODE_EMU && tck_d;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_dcc_send_irq <= 1'b0;
            o_dcc_receive_irq <= 1'b0;
            o_chip_id <= '0;
        end else begin
            o_dcc_send_irq <= i_debug_channel_send_flag;
            o_dcc_receive_irq <= i_debug_channel_receive_flag;
            o_chip_id <= CHIP_ID;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);
    property p_mode_fixed;
        por_done |=> $stable(o_port_mode);
    endproperty
    a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed after reset");
    property p_returned_test_clock_off;
        o_port_mode == MODE_BSCAN |=> !o_returned_test_clock;
    endproperty
    a_returned_test_clock_off: assert property (p_returned_test_clock_off) else $error("returned clock in scan mode");
    property p_scan_id;
        tck_rise && state == TS_CAP_DR && dr_sel == DR_ID && o_port_mode == MODE_BSCAN
            |=> sr[0] == 1'b1 && sr[31:28] == ID_VERSION && sr[27:12] == ID_PART;
    endproperty
    a_scan_id: assert property (p_scan_id) else $error("bad scan id capture");
    property p_core_id;
        tck_rise && state == TS_CAP_DR && dr_sel == DR_ID && o_port_mode == MODE_EMU
            |=> sr[31:0] == CORE_ID;
    endproperty
    a_core_id: assert property (p_core_id) else $error("bad core id capture");
    property p_no_chain_in_scan;
        o_port_mode == MODE_BSCAN |-> dr_sel != DR_CH1 && dr_sel != DR_CH2 && dr_sel != DR_CHSEL;
    endproperty
    a_no_chain_in_scan: assert property (p_no_chain_in_scan) else $error("chain in scan mode");
    property p_no_extest_emu;
        o_port_mode == MODE_EMU |=> !o_pin_extest;
    endproperty
    a_no_extest_emu: assert property (p_no_extest_emu) else $error("extest in emu mode");
    property p_block;
        i_access_block |=> !o_core_insn_valid && !o_emu_write;
    endproperty
    a_block: assert property (p_block) else $error("access not blocked");
    property p_tdo_shift;
        tck_fall && state == TS_SHF_DR |=> o_tdo == $past(sr[0]) && o_tdo_en;
    endproperty
    a_tdo_shift: assert property (p_tdo_shift) else $error("tdo not from register");
    property p_tdi_bypass;
        tck_rise && state == TS_SHF_DR && dr_sel == DR_BYP |=> sr[0] == $past(tdi_s);
    endproperty
    a_tdi_bypass: assert property (p_tdi_bypass) else $error("tdi not shifted in");
    property p_por;
        !por_done |-> !o_test_reset_n && state == TS_RESET ##1 1'b1;
    endproperty
    a_por: assert property (p_por) else $error("test reset not held");
    property p_irq;
        1'b1 |=> o_dcc_send_irq == $past(i_debug_channel_send_flag)
            && o_dcc_receive_irq == $past(i_debug_channel_receive_flag);
    endproperty
    a_irq: assert property (p_irq) else $error("channel flag lost");
    c_insn: cover property (o_core_insn_valid);
    c_emu_write: cover property (o_emu_write);
    c_extest: cover property (tck_rise && state == TS_UPD_DR && o_pin_extest);
    c_returned_test_clock: cover property (o_returned_test_clock);
endmodule : sdp_top

//--- tb/sdp_probe.sv
// test port probe model: makes test clock, mode select, data in and test reset
`timescale 1ns/10ps
module sdp_probe (
    input wire logic i_tdo,
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    output logic o_test_reset_n,
    output logic o_factory_test_select
);
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        o_test_reset_n = 1'b1;
        o_factory_test_select = 1'b0;
    end

    // one 125 ns test clock period, well under a sixth of the core clock
    task automatic pulse(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #62.5;
        tdo = i_tdo;
        o_tck = 1'b1;
        #62.5;
        o_tck = 1'b0;
    endtask : pulse

    task automatic tap_reset();
        logic b;
        repeat (5) pulse(1'b1, 1'b0, b);
        pulse(1'b0, 1'b0, b);
    endtask : tap_reset

    // idle to idle; clock stands low and data in flips once released
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic b;
        dout = '0;
        pulse(1'b1, 1'b0, b);
        if (ir) pulse(1'b1, 1'b0, b);
        pulse(1'b0, 1'b0, b);
        pulse(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], b);
            dout[i] = b;
        end
        pulse(1'b1, ~din[n-1], b);
        pulse(1'b0, ~din[n-1], b);
    endtask : scan

    // held low 40 ns, above 2.5 core clock periods
    task automatic test_reset();
        logic b;
        o_test_reset_n = 1'b0;
        #40;
        o_test_reset_n = 1'b1;
        #40;
        pulse(1'b0, 1'b0, b);
    endtask : test_reset
endmodule : sdp_probe

//--- tb/sdp_top_test.sv
// self-checking bench for the scan and debug port select block
`timescale 1ns/10ps
module sdp_top_test;
    import sdp_pkg::*;
    localparam logic [3:0] VER = 4'h3; // arbitrary value
    localparam logic [15:0] PART = 16'hA5C1; // arbitrary value
    localparam logic [10:0] MAKER = 11'h2B4; // arbitrary value
    localparam logic [31:0] CORE = 32'h6D1E_42B8; // arbitrary value
    localparam logic [31:0] CHIP = 32'h3C45_9A10; // arbitrary value
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic sel = 1'b0;
    logic dbg = 1'b1;
    logic blk = 1'b0;
    logic snd = 1'b0;
    logic rcv = 1'b0;
    logic [31:0] rdata = 32'h1234_5678;
    logic [31:0] erdata = 32'h0F0F_5A5A;
    logic [15:0] pins = 16'hC3A5;
    logic tck, tms, tdi, trst_n, tdo, tdo_en, returned_test_clock, ptrst_n, ins_v, e_wr, ext, s_irq, r_irq;
    sdp_mode_t mode;
    logic [31:0] ins, e_wd, chip_id;
    logic [4:0] e_a;
    logic [15:0] drv;
    logic [63:0] q;
    logic rt_seen = 1'b0;
    logic en_seen = 1'b0;
    logic fts;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_ins = 0;
    int n_wr = 0;

    always #5 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        if (ins_v === 1'b1) n_ins++;
        if (e_wr === 1'b1) n_wr++;
        if (returned_test_clock === 1'b1) rt_seen = 1'b1;
        if (tdo_en === 1'b1) en_seen = 1'b1;
    end

    sdp_top #(.BSR_LEN(16), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER),
        .CORE_ID(CORE), .CHIP_ID(CHIP)) u_sdp_top (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .i_test_reset_n(trst_n), .i_scan_mode_select(sel), .o_tdo(tdo),
        .o_tdo_en(tdo_en), .o_returned_test_clock(returned_test_clock), .o_test_reset_n(ptrst_n),
        .o_port_mode(mode), .i_core_debug_state(dbg), .i_core_rdata(rdata),
        .o_core_insn(ins), .o_core_insn_valid(ins_v), .i_emu_rdata(erdata),
        .o_emu_addr(e_a), .o_emu_wdata(e_wd), .o_emu_write(e_wr), .i_pin_state(pins),
        .o_pin_drive(drv), .o_pin_extest(ext), .i_debug_channel_send_flag(snd),
        .i_debug_channel_receive_flag(rcv), .i_access_block(blk),
        .o_dcc_send_irq(s_irq), .o_dcc_receive_irq(r_irq), .o_chip_id(chip_id)
    );

    sdp_probe u_sdp_probe (
        .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_test_reset_n(trst_n),
        .o_factory_test_select(fts)
    );

    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : wt

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic tend(input string s);
        $display("test %s done", s);
    endtask : tend

    task automatic conclude();
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // full chip reset, the only way a new mode is taken
    task automatic chip_reset(input logic s);
        wt(1);
        i_reset_n = 1'b0;
        sel = s;
        wt(10);
        i_reset_n = 1'b1;
        wt(3);
        chk(ptrst_n, 1'b0);
        wt(20);
        chk(ptrst_n, 1'b1);
        rt_seen = 1'b0;
        u_sdp_probe.tap_reset();
    endtask : chip_reset

    task automatic ir(input logic [3:0] c);
        u_sdp_probe.scan(1'b1, 4, {60'h0, c}, q);
        chk(q[3:0], IR_CAPTURE);
    endtask : ir

    task automatic dr(input int n, input logic [63:0] d);
        u_sdp_probe.scan(1'b0, n, d, q);
    endtask : dr

    initial begin
        #800_000;
        n_mismatch++;
        conclude();
    end

    initial begin
        chip_reset(1'b0);
        chk(mode, MODE_EMU);
        chk(chip_id, CHIP);
        dr(32, 64'h0);
        chk(q[31:0], CORE);
        chk(rt_seen, 1'b1);
        chk({en_seen, tdo_en}, 2'b10);
        ir(INS_BYPASS);
        dr(8, 64'hB5);
        chk(q[7:0], 8'h6A);
        for (int k = 0; k < 2; k++) begin
            wt(1);
            {snd, rcv} = (k == 0) ? 2'b10 : 2'b01;
            wt(2);
            chk({s_irq, r_irq}, {snd, rcv});
        end
        tend("emulation id bypass channel");
        ir(INS_SCAN_N);
        dr(4, {60'h0, CHAIN_DEBUG});
        ir(INS_INTEST);
        for (int k = 2; k >= 0; k--) begin
            wt(1);
            blk = (k == 1);
            dbg = (k != 2);
            dr(33, {32'h0, 32'hE92D_0FFF ^ 32'(k)});
            chk(q[32:0], {dbg, rdata});
            chk(n_ins, k == 0);
        end
        chk(ins, 32'hE92D_0FFF);
        ir(INS_SCAN_N);
        dr(4, {60'h0, CHAIN_EMU});
        ir(INS_INTEST);
        dr(38, {26'h0, 1'b1, 5'h15, 32'hCAFE_0123});
        chk({n_wr[0], e_a, e_wd}, {1'b1, 5'h15, 32'hCAFE_0123});
        dr(38, {26'h0, 1'b0, 5'h0A, 32'h0});
        chk(n_wr, 1);
        tend("emulation chains");
        chip_reset(1'b1);
        chk(mode, MODE_BSCAN);
        dr(32, 64'h0);
        chk(q[31:0], {VER, PART, MAKER, 1'b1});
        ir(INS_SAMPLE);
        dr(16, 64'h5A0F);
        chk(q[15:0], pins);
        ir(INS_EXTEST);
        dr(16, 64'h96E1);
        chk({ext, drv}, {1'b1, 16'h96E1});
        ir(INS_BYPASS);
        dr(4, 64'h3);
        chk({ext, q[3:0]}, {1'b0, 4'h6});
        wt(1);
        sel = 1'b0;
        u_sdp_probe.tap_reset();
        chk({mode, rt_seen}, {MODE_BSCAN, 1'b0});
        ir(INS_BYPASS);
        u_sdp_probe.test_reset();
        dr(32, 64'h0);
        chk(q[31:0], {VER, PART, MAKER, 1'b1});
        chip_reset(1'b0);
        chk(mode, MODE_EMU);
        tend("boundary scan");
        conclude();
    end
endmodule : sdp_top_test
